// ==== common/sdi_pkg.sv ====
// constants and types for the stepper drive interface
package sdi_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   // fastest step rate the power controller accepts
   localparam int unsigned STEP_MAX_HZ   = 500_000;
   localparam int unsigned STEP_MIN_CYC  = (CLK_HZ + STEP_MAX_HZ - 1) / STEP_MAX_HZ;
   localparam int unsigned STEP_HI_CYC   = (STEP_MIN_CYC + 1) / 2;
   // direction setup before a rising edge
   localparam int unsigned DIR_SETUP_CYC = 2;
   localparam int unsigned PWM_BITS      = 8;
   localparam int unsigned CNT_W         = 8;

   // register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STEP   = 8'h04;
   localparam logic [7:0] REG_PWM    = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;

   // control fields
   localparam int unsigned CTRL_EN_BIT  = 0;
   localparam int unsigned CTRL_DIR_BIT = 1;
   // step request fields
   localparam int unsigned STEP_CNT_LSB = 0;
   localparam int unsigned STEP_CNT_MSB = 15;
   // status fields
   localparam int unsigned ST_READY_BIT = 0;
   localparam int unsigned ST_MOT_BIT   = 1;
   localparam int unsigned ST_ROT_BIT   = 2;
   localparam int unsigned ST_CTL_BIT   = 3;
   localparam int unsigned ST_BUSY_BIT  = 4;
   localparam int unsigned ST_LEFT_LSB  = 16;

   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [PWM_BITS-1:0] PWM_RST = 8'h00;

   // differential output pair
   typedef struct packed {
      logic p;
      logic n;
   } sdi_diff_t;

   // status inputs from controller, active high after decode
   typedef struct packed {
      logic ready;
      logic mot_warn;
      logic rot_fault;
      logic ctl_warn;
   } sdi_stat_t;

   typedef enum logic [1:0] {
      SDI_IDLE  = 2'b00,
      SDI_SETUP = 2'b01,
      SDI_HIGH  = 2'b10,
      SDI_LOW   = 2'b11
   } sdi_state_t;
endpackage

// ==== design/sdi_top.sv ====
// stepper drive interface: step/dir, enable/ready, pwm, status inputs, apb
// Contract
// (R1) each rising edge of the step output moves the motor exactly one step, one pulse per step.
// (R2) the direction level picks the rotation sense of the step taken on each rising edge.
// (R3) after enable is raised, the controller answers by raising ready.
// (R4) a pwm output whose duty sets current from zero up to full nominal.
// (R5) step, direction, enable and pwm each drive with an inverted complement line.
// (R6) motor overtemperature/line-break and rotation fault inputs are taken in.
// (R7) the controller's own overtemperature warning input is shown as status.
// (R8) step rate never exceeds the controller's maximum pulse frequency.
// (R9) controller status inputs change slowly, so they may be sampled slowly.
// (R10) no steps until ready follows enable, and direction holds steady around each edge.
`timescale 1ns/1ps
`default_nettype none
module sdi_top #(
   parameter int unsigned STEP_W = 16
) (
   // clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_n_i,
   // apb slave
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic [31:0]            prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // controller outputs
   output sdi_pkg::sdi_diff_t     step_o,
   output sdi_pkg::sdi_diff_t     dir_o,
   output sdi_pkg::sdi_diff_t     enable_o,
   output sdi_pkg::sdi_diff_t     pwm_o,
   // controller inputs, active low pins
   input  wire logic              ready_n_i,
   input  wire logic              motor_overtemp_warn_n_i,
   input  wire logic              rotation_monitor_fault_n_i,
   input  wire logic              ctl_overtemp_warn_n_i
);
   // status field holds at most 16 bits of remaining count
   if (STEP_W < 1 || STEP_W > 16) begin : g_step_w_check
      $error("STEP_W out of range");
   end

   // synchronisers: three stages, change once stages two and three agree
   logic [3:0] s1_r, s2_r, s3_r, stat_r;
   logic [3:0] s1_nxt, stat_nxt;
   always_comb begin
      s1_nxt = ~{ready_n_i, motor_overtemp_warn_n_i,
                 rotation_monitor_fault_n_i, ctl_overtemp_warn_n_i}; // see (R6) (R7)
      stat_nxt = stat_r;
      for (int i = 0; i < 4; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            stat_nxt[i] = s3_r[i]; // see (R9)
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s1_r   <= 4'h0;
         s2_r   <= 4'h0;
         s3_r   <= 4'h0;
         stat_r <= 4'h0;
      end else begin
         s1_r   <= s1_nxt;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         stat_r <= stat_nxt;
      end
   end
   sdi_pkg::sdi_stat_t st;
   assign st = stat_r;

   // register file
   logic                         en_r, en_nxt, dirc_r, dirc_nxt;
   logic                         en_n_r;
   logic [sdi_pkg::PWM_BITS-1:0] duty_r, duty_nxt;
   logic [STEP_W-1:0]            left_r, left_nxt;
   logic [31:0]                  rd_r, rd_nxt;
   logic                         rdy_r, rdy_nxt, err_r, err_nxt;
   logic                         access, wr, dec_ok;
   logic                         busy, take_step;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == sdi_pkg::REG_CTRL) || (a == sdi_pkg::REG_STEP) ||
                (a == sdi_pkg::REG_PWM) || (a == sdi_pkg::REG_STATUS);
   endfunction

   assign access = psel_i && penable_i && !rdy_r;
   assign wr     = access && pwrite_i;
   assign dec_ok = addr_ok(paddr_i);

   always_comb begin
      en_nxt   = en_r;
      dirc_nxt = dirc_r;
      duty_nxt = duty_r;
      left_nxt = left_r;
      rd_nxt   = rd_r;
      rdy_nxt  = access;
      err_nxt  = access && !dec_ok;
      if (take_step) begin
         left_nxt = left_r - STEP_W'(1); // see (R1)
      end
      if (wr && paddr_i == sdi_pkg::REG_CTRL) begin
         en_nxt = pwdata_i[sdi_pkg::CTRL_EN_BIT];
         // direction only changes with no step pending
         if (!busy) begin
            dirc_nxt = pwdata_i[sdi_pkg::CTRL_DIR_BIT]; // see (R10)
         end
      end
      if (wr && paddr_i == sdi_pkg::REG_STEP && !busy) begin
         left_nxt = pwdata_i[STEP_W-1:0];
      end
      if (wr && paddr_i == sdi_pkg::REG_PWM) begin
         duty_nxt = pwdata_i[sdi_pkg::PWM_BITS-1:0];
      end
      if (!en_nxt) begin
         left_nxt = '0;
      end
      if (access && !pwrite_i) begin
         unique case (paddr_i)
            sdi_pkg::REG_CTRL: begin
               rd_nxt = {30'h0, dirc_r, en_r};
            end
            sdi_pkg::REG_STEP: begin
               rd_nxt = 32'(left_r);
            end
            sdi_pkg::REG_PWM: begin
               rd_nxt = 32'(duty_r);
            end
            sdi_pkg::REG_STATUS: begin
               rd_nxt = {16'(left_r), 11'h0, busy, st.ctl_warn, st.rot_fault,
                         st.mot_warn, st.ready}; // see (R6) (R7)
            end
            default: begin
               rd_nxt = 32'h0;
            end
         endcase
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         en_r   <= sdi_pkg::CTRL_RST[sdi_pkg::CTRL_EN_BIT];
         en_n_r <= ~sdi_pkg::CTRL_RST[sdi_pkg::CTRL_EN_BIT];
         dirc_r <= sdi_pkg::CTRL_RST[sdi_pkg::CTRL_DIR_BIT];
         duty_r <= sdi_pkg::PWM_RST;
         left_r <= '0;
         rd_r   <= 32'h0;
         rdy_r  <= 1'b0;
         err_r  <= 1'b0;
      end else begin
         en_r   <= en_nxt;
         en_n_r <= ~en_nxt;
         dirc_r <= dirc_nxt;
         duty_r <= duty_nxt;
         left_r <= left_nxt;
         rd_r   <= rd_nxt;
         rdy_r  <= rdy_nxt;
         err_r  <= err_nxt;
      end
   end

   // step sequencer
   sdi_pkg::sdi_state_t state_r, state_nxt;
   logic [sdi_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic step_r, step_nxt, dir_r, dir_nxt;
   logic step_n_r, dir_n_r;
   assign busy = (state_r != sdi_pkg::SDI_IDLE) || (left_r != '0);
   // count only when the pulse really starts, an aborted setup keeps it
   assign take_step = (state_r == sdi_pkg::SDI_SETUP) && (cnt_r == '0) &&
                      en_r && st.ready; // see (R1)

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r == '0) ? cnt_r : cnt_r - 8'h01;
      step_nxt  = step_r;
      dir_nxt   = dir_r;
      unique case (state_r)
         sdi_pkg::SDI_IDLE: begin
            // wait for ready after enable before stepping
            if (en_r && st.ready && left_r != '0) begin // see (R3) (R10)
               dir_nxt   = dirc_r; // see (R2)
               cnt_nxt   = 8'(sdi_pkg::DIR_SETUP_CYC - 1);
               state_nxt = sdi_pkg::SDI_SETUP;
            end
         end
         sdi_pkg::SDI_SETUP: begin
            if (!en_r || !st.ready) begin
               state_nxt = sdi_pkg::SDI_IDLE;
            end else if (cnt_r == '0) begin
               step_nxt  = 1'b1; // see (R1)
               cnt_nxt   = 8'(sdi_pkg::STEP_HI_CYC - 1);
               state_nxt = sdi_pkg::SDI_HIGH;
            end
         end
         sdi_pkg::SDI_HIGH: begin
            if (cnt_r == '0) begin
               step_nxt  = 1'b0;
               // low time fills out the minimum period
               cnt_nxt   = 8'(sdi_pkg::STEP_MIN_CYC - sdi_pkg::STEP_HI_CYC
                              - sdi_pkg::DIR_SETUP_CYC); // see (R8)
               state_nxt = sdi_pkg::SDI_LOW;
            end
         end
         sdi_pkg::SDI_LOW: begin
            if (cnt_r == '0) begin
               state_nxt = sdi_pkg::SDI_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_r <= sdi_pkg::SDI_IDLE;
         cnt_r   <= '0;
         step_r  <= 1'b0;
         dir_r   <= 1'b0;
         step_n_r <= 1'b1;
         dir_n_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         step_r  <= step_nxt;
         dir_r   <= dir_nxt;
         step_n_r <= ~step_nxt;
         dir_n_r <= ~dir_nxt;
      end
   end

   // pwm: duty of 255 holds high for full current
   logic [sdi_pkg::PWM_BITS-1:0] pcnt_r, pcnt_nxt;
   logic pwm_r, pwm_nxt;
   logic pwm_n_r;
   always_comb begin
      pcnt_nxt = pcnt_r + 8'h01;
      pwm_nxt  = (duty_r == 8'hff) || (pcnt_r < duty_r); // see (R4)
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pcnt_r <= 8'h00;
         pwm_r  <= 1'b0;
         pwm_n_r <= 1'b1;
      end else begin
         pcnt_r <= pcnt_nxt;
         pwm_r  <= pwm_nxt;
         pwm_n_r <= ~pwm_nxt;
      end
   end

   // outputs, each line its own flop so no inverter sits after a register
   assign step_o    = '{p: step_r, n: step_n_r}; // see (R5)
   assign dir_o     = '{p: dir_r, n: dir_n_r};
   assign enable_o  = '{p: en_r, n: en_n_r};
   assign pwm_o     = '{p: pwm_r, n: pwm_n_r};
   assign prdata_o  = rd_r;
   assign pready_o  = rdy_r;
   assign pslverr_o = err_r;

   int unsigned prd_cnt;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || (step_r && !$past(step_r))) begin
         prd_cnt <= 1;
      end else if (prd_cnt < 1000) begin
         prd_cnt <= prd_cnt + 1;
      end
   end

   // pulse width counted here, too long to unroll as a repetition
   logic [sdi_pkg::CNT_W-1:0] hi_len;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || !step_r) begin
         hi_len <= '0;
      end else if (hi_len != '1) begin
         hi_len <= hi_len + 8'h01;
      end
   end

   sequence s_fall;
      $fell(step_r);
   endsequence
   sequence s_rise;
      $rose(step_r);
   endsequence
   property p_step_rate;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         s_rise |-> $past(prd_cnt) >= sdi_pkg::STEP_MIN_CYC;
   endproperty
   a_step_rate: assert property (p_step_rate) else $error("step too fast"); // see (R8)

   property p_ready_first;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         s_rise |-> $past(st.ready) && $past(en_r);
   endproperty
   a_ready_first: assert property (p_ready_first) else $error("step without ready"); // see (R10)

   property p_dir_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         s_rise |-> $stable(dir_r) && ($past(dir_r) == $past(dir_r, 2));
   endproperty
   a_dir_hold: assert property (p_dir_hold) else $error("dir moved at edge"); // see (R2)

   property p_count;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         take_step |=> left_r == $past(left_r) - STEP_W'(1) || !en_r;
   endproperty
   a_count: assert property (p_count) else $error("step count wrong"); // see (R1)

   property p_high_len;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         s_fall |-> hi_len == sdi_pkg::STEP_HI_CYC;
   endproperty
   a_high_len: assert property (p_high_len) else $error("pulse width wrong"); // see (R1)

   property p_compl;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (step_o.n != step_o.p) && (dir_o.n != dir_o.p) &&
         (pwm_o.n != pwm_o.p) && (enable_o.n != enable_o.p);
   endproperty
   a_compl: assert property (p_compl) else $error("pair not complementary"); // see (R5)

   property p_pwm_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         (duty_r == 8'h00) [*2] |-> !pwm_r;
   endproperty
   a_pwm_zero: assert property (p_pwm_zero) else $error("pwm on at zero duty"); // see (R4)

   property p_disable_stops;
      @(posedge core_clk_i) disable iff (!rst_n_i)
         !en_r [*2] |-> !$rose(step_r);
   endproperty
   a_disable_stops: assert property (p_disable_stops) else $error("step while off"); // see (R3)
endmodule
`default_nettype wire

// ==== verif/sdi_ctl_model.sv ====
// behavioural model of the power controller facing the interface
`timescale 1ns/1ps
`default_nettype none
module sdi_ctl_model (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   // answer delay in cycles
   input  wire logic [31:0]        ready_dly_i,
   // pairs from the device
   input  wire sdi_pkg::sdi_diff_t step_i,
   input  wire sdi_pkg::sdi_diff_t dir_i,
   input  wire sdi_pkg::sdi_diff_t enable_i,
   input  wire sdi_pkg::sdi_diff_t pwm_i,
   // answers
   output logic                    ready_n_o,
   output int                      pos_o,
   output int                      bad_o
);
   int   cnt;
   int   gap;
   logic step_q;
   logic dir_q;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt = 0;
         ready_n_o <= 1'b1;
         pos_o <= 0;
         bad_o <= 0;
         gap <= 1000;
         step_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         cnt = enable_i.p ? cnt + 1 : 0;
         // open input reads inactive once enable is gone
         ready_n_o <= !(enable_i.p && cnt > int'(ready_dly_i));
         step_q <= step_i.p;
         dir_q <= dir_i.p;
         gap <= (step_i.p && !step_q) ? 1 : gap + 1;
         if (step_i.p && !step_q) begin
            pos_o <= pos_o + (dir_i.p ? -1 : 1);
            bad_o <= bad_o + int'(gap < 50) + int'(ready_n_o) + int'(dir_i.p != dir_q);
         end else begin
            bad_o <= bad_o + int'(step_i.p && dir_i.p != dir_q)
                     + int'(step_i.p == step_i.n) + int'(dir_i.p == dir_i.n)
                     + int'(enable_i.p == enable_i.n) + int'(pwm_i.p == pwm_i.n);
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/stepper_drive_interface_tb.sv ====
// self-checking testbench for the stepper drive interface
`timescale 1ns/1ps
`default_nettype none
module stepper_drive_interface_tb;
   logic               clk;
   logic               rst_n;
   logic               psel;
   logic               penable;
   logic               pwrite;
   logic [7:0]         paddr;
   logic [31:0]        pwdata;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   sdi_pkg::sdi_diff_t step_w;
   sdi_pkg::sdi_diff_t dir_w;
   sdi_pkg::sdi_diff_t en_w;
   sdi_pkg::sdi_diff_t pwm_w;
   logic               ready_n;
   logic               mot_n;
   logic               rot_n;
   logic               ctl_n;
   logic [31:0]        rd;
   logic [31:0]        seed;
   logic               er;
   logic [7:0]         duty;
   int                 n_fail;
   int                 n_compared;
   int                 pos;
   int                 bad;
   int                 expos;
   int                 n;
   int                 hi;
   logic               d;

   sdi_top DUT (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .step_o(step_w), .dir_o(dir_w),
      .enable_o(en_w), .pwm_o(pwm_w), .ready_n_i(ready_n),
      .motor_overtemp_warn_n_i(mot_n), .rotation_monitor_fault_n_i(rot_n),
      .ctl_overtemp_warn_n_i(ctl_n));
   sdi_ctl_model u_ctl (.clk_i(clk), .rst_n_i(rst_n), .ready_dly_i(60), .step_i(step_w),
      .dir_i(dir_w), .enable_i(en_w), .pwm_i(pwm_w), .ready_n_o(ready_n), .pos_o(pos),
      .bad_o(bad));

   always #20 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // held from setup until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int t;
      t = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t >= 20) n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never reassigns in this step
      @(posedge clk);
   endtask

   function automatic logic [31:0] exp_status(input logic r, m, f, c);
      return {28'h0, c, f, m, r};
   endfunction

   // second step write lands while busy and must be dropped
   task automatic run_steps(input logic dr, input logic [15:0] cnt);
      apb(1'b1, sdi_pkg::REG_CTRL, {30'h0, dr, 1'b1});
      apb(1'b1, sdi_pkg::REG_STEP, {16'h0, cnt});
      apb(1'b1, sdi_pkg::REG_STEP, 32'h0000_0007);
      repeat (200) begin
         repeat (20) @(posedge clk);
         apb(1'b0, sdi_pkg::REG_STATUS, 32'h0);
         if (rd[sdi_pkg::ST_BUSY_BIT] === 1'b0) break;
      end
   endtask

   task automatic finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #2_000_000;
      n_fail++;
      finish_test;
   end

   initial begin
      clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; mot_n = 1'b1; rot_n = 1'b1; ctl_n = 1'b1;
      n_fail = 0; n_compared = 0; expos = 0; seed = 32'hc7ac;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("idle pairs", {24'h0, step_w, dir_w, en_w, pwm_w}, 32'h0000_0055);
      apb(1'b0, sdi_pkg::REG_CTRL, 32'h0);
      chk("ctrl reset", rd, sdi_pkg::CTRL_RST);
      apb(1'b0, sdi_pkg::REG_PWM, 32'h0);
      chk("pwm reset", rd, {24'h0, sdi_pkg::PWM_RST});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // first run waits out the slow ready answer
      run_steps(1'b0, 16'd3);
      expos = 3;
      chk("enable pair", {30'h0, en_w}, 32'h2);
      for (int i = 0; i < 5; i++) begin
         n = ($random(seed) & 3) + 1;
         d = 1'($random(seed));
         run_steps(d, n[15:0]);
         expos = d ? expos - n : expos + n;
      end
      chk("position", pos, expos);
      chk("step timing faults", bad, 32'h0);
      for (int i = 0; i < 4; i++) begin
         duty = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
         apb(1'b1, sdi_pkg::REG_PWM, {24'h0, duty});
         repeat (300) @(posedge clk);
         hi = 0;
         repeat (256) begin
            @(posedge clk);
            hi += pwm_w.p;
         end
         chk("pwm high count", hi, (duty == 8'hff) ? 256 : duty);
      end
      for (int i = 0; i < 4; i++) begin
         // status pins change only every sixteen cycles, slow inputs
         {mot_n, rot_n, ctl_n} <= 3'($random(seed));
         repeat (12) @(posedge clk);
         apb(1'b0, sdi_pkg::REG_STATUS, 32'h0);
         chk("status", rd, exp_status(1'b1, ~mot_n, ~rot_n, ~ctl_n));
      end
      apb(1'b1, sdi_pkg::REG_CTRL, 32'h0);
      chk("enable off", {30'h0, en_w}, 32'h1);
      repeat (12) @(posedge clk);
      apb(1'b0, sdi_pkg::REG_STATUS, 32'h0);
      chk("ready gone", rd, exp_status(1'b0, ~mot_n, ~rot_n, ~ctl_n));
      chk("faults at end", bad, 32'h0);
      finish_test;
   end
endmodule
`default_nettype wire
